// ### design/rlbc_core.sv
// Relay output selector and braking transistor hysteresis with register port
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module rlbc_core #(
    parameter logic [rlbc_pkg::DATA_W-1:0] BT_LEVEL_MIN = rlbc_pkg::BT_MIN,
    parameter logic [rlbc_pkg::DATA_W-1:0] BT_LEVEL_MAX = rlbc_pkg::BT_MAX
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [rlbc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [rlbc_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [rlbc_pkg::DATA_W-1:0] rd_data_o,
    input wire rlbc_pkg::rlbc_meas_s meas_i,
    output logic relay_output_o,
    output logic brake_transistor_o,
    output logic parameter_setting_error_o
);

    // Values outside the accepted range are pinned to the nearest limit
    function automatic logic [rlbc_pkg::DATA_W-1:0] clamp(
        input logic [rlbc_pkg::DATA_W-1:0] val,
        input logic [rlbc_pkg::DATA_W-1:0] lo,
        input logic [rlbc_pkg::DATA_W-1:0] hi
    );
        logic [rlbc_pkg::DATA_W-1:0] res;
        res = val;
        if (val < lo) begin
            res = lo;
        end else if (val > hi) begin
            res = hi;
        end
        return res;
    endfunction

    rlbc_pkg::rlbc_cfg_s cfg_q;
    rlbc_pkg::rlbc_cfg_s cfg_d;
    logic relay_logic_q;
    logic relay_logic_d;
    logic relay_out_q;
    logic relay_out_d;
    logic brake_hold_q;
    logic brake_hold_d;
    logic bt_q;
    logic bt_d;
    logic param_err_q;
    logic param_err_d;
    logic overcur_q;
    logic overcur_d;
    logic [rlbc_pkg::DATA_W-1:0] rd_data_q;
    logic [rlbc_pkg::DATA_W-1:0] rd_data_d;
    logic [rlbc_pkg::DATA_W-1:0] reach_below;
    logic reach_in;
    logic win_set_in;
    logic win_out_in;
    logic overcur;
    logic [rlbc_pkg::DATA_W-1:0] status;

    // Configuration registers written over the register port
    always_comb begin
        cfg_d = cfg_q;
        if (wr_en_i) begin
            unique case (addr_i)
                rlbc_pkg::ADDR_CTRL: begin
                    cfg_d.func_sel = wr_data_i[rlbc_pkg::CTRL_SEL_LSB +: rlbc_pkg::SEL_W];
                    cfg_d.contact_nc = wr_data_i[rlbc_pkg::CTRL_CONTACT_BIT];
                end
                rlbc_pkg::ADDR_FREQ_LEVEL: begin
                    cfg_d.freq_level = clamp(wr_data_i, rlbc_pkg::ZERO,
                                             rlbc_pkg::FREQ_LEVEL_MAX);
                end
                rlbc_pkg::ADDR_FREQ_WIDTH: begin
                    cfg_d.freq_width = clamp(wr_data_i, rlbc_pkg::ZERO,
                                             rlbc_pkg::FREQ_WIDTH_MAX);
                end
                rlbc_pkg::ADDR_CUR_LEVEL: begin
                    cfg_d.cur_level = clamp(wr_data_i, rlbc_pkg::CUR_LEVEL_MIN,
                                            rlbc_pkg::CUR_LEVEL_MAX);
                end
                rlbc_pkg::ADDR_CUR_PERIOD: begin
                    // Stored and read back; it does not delay the relay
                    cfg_d.cur_period = clamp(wr_data_i, rlbc_pkg::CUR_PERIOD_MIN,
                                             rlbc_pkg::CUR_PERIOD_MAX);
                end
                rlbc_pkg::ADDR_BRK_RELEASE: begin
                    cfg_d.brk_release = clamp(wr_data_i, rlbc_pkg::ZERO,
                                              rlbc_pkg::BRK_LEVEL_MAX);
                end
                rlbc_pkg::ADDR_BRK_ENGAGE: begin
                    cfg_d.brk_engage = clamp(wr_data_i, rlbc_pkg::ZERO,
                                             rlbc_pkg::BRK_LEVEL_MAX);
                end
                rlbc_pkg::ADDR_BT_ON: begin
                    cfg_d.bt_on = clamp(wr_data_i, BT_LEVEL_MIN, BT_LEVEL_MAX);
                end
                rlbc_pkg::ADDR_BT_OFF: begin
                    cfg_d.bt_off = clamp(wr_data_i, BT_LEVEL_MIN, BT_LEVEL_MAX);
                end
                default: begin
                    // Status and unmapped indices ignore writes
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cfg_q.func_sel <= rlbc_pkg::RLBC_FN_RUN;
            cfg_q.contact_nc <= 1'b0;
            cfg_q.freq_level <= rlbc_pkg::RST_FREQ_LEVEL;
            cfg_q.freq_width <= rlbc_pkg::RST_FREQ_WIDTH;
            cfg_q.cur_level <= rlbc_pkg::RST_CUR_LEVEL;
            cfg_q.cur_period <= rlbc_pkg::RST_CUR_PERIOD;
            cfg_q.brk_release <= rlbc_pkg::RST_BRK_LEVEL;
            cfg_q.brk_engage <= rlbc_pkg::RST_BRK_LEVEL;
            cfg_q.bt_on <= rlbc_pkg::RST_BT_ON;
            cfg_q.bt_off <= rlbc_pkg::RST_BT_OFF;
        end else if (ce_i) begin
            cfg_q <= cfg_d;
        end
    end

    // Frequency reached: [set - width - tol, set + tol]
    assign reach_below = cfg_q.freq_width + rlbc_pkg::FREQ_TOL;

    rlbc_window #(
        .W(rlbc_pkg::DATA_W)
    ) u_reach (
        .value_i(meas_i.out_freq),
        .base_i(meas_i.set_freq),
        .below_i(reach_below),
        .above_i(rlbc_pkg::FREQ_TOL),
        .inside_o(reach_in)
    );

    // Detection window around the level, checked for both frequencies
    rlbc_window #(
        .W(rlbc_pkg::DATA_W)
    ) u_win_set (
        .value_i(meas_i.set_freq),
        .base_i(cfg_q.freq_level),
        .below_i(cfg_q.freq_width),
        .above_i(cfg_q.freq_width),
        .inside_o(win_set_in)
    );

    rlbc_window #(
        .W(rlbc_pkg::DATA_W)
    ) u_win_out (
        .value_i(meas_i.out_freq),
        .base_i(cfg_q.freq_level),
        .below_i(cfg_q.freq_width),
        .above_i(cfg_q.freq_width),
        .inside_o(win_out_in)
    );

    assign overcur = meas_i.out_cur > cfg_q.cur_level;

    // External brake state: set on acceleration, cleared on deceleration
    always_comb begin
        brake_hold_d = brake_hold_q;
        if (meas_i.accel && (meas_i.out_freq >= cfg_q.brk_release)) begin
            brake_hold_d = 1'b1;
        end else if (meas_i.decel && (meas_i.out_freq <= cfg_q.brk_engage)) begin
            brake_hold_d = 1'b0;
        end
    end

    // Relay function selection
    always_comb begin
        relay_logic_d = 1'b0;
        unique case (cfg_q.func_sel)
            rlbc_pkg::RLBC_FN_RUN: begin
                relay_logic_d = meas_i.run;
            end
            rlbc_pkg::RLBC_FN_FAULT: begin
                relay_logic_d = meas_i.fault;
            end
            rlbc_pkg::RLBC_FN_FREQ_REACHED: begin
                relay_logic_d = meas_i.run && reach_in;
            end
            rlbc_pkg::RLBC_FN_FREQ_WINDOW: begin
                relay_logic_d = win_set_in && win_out_in;
            end
            rlbc_pkg::RLBC_FN_ABOVE_LEVEL: begin
                relay_logic_d = meas_i.out_freq > cfg_q.freq_level;
            end
            rlbc_pkg::RLBC_FN_BELOW_LEVEL: begin
                relay_logic_d = meas_i.out_freq < cfg_q.freq_level;
            end
            rlbc_pkg::RLBC_FN_OVERCURRENT: begin
                // Follows the comparison both ways, no latching
                relay_logic_d = overcur;
            end
            rlbc_pkg::RLBC_FN_EXT_BRAKE: begin
                relay_logic_d = brake_hold_d;
            end
            default: begin
                relay_logic_d = 1'b0;
            end
        endcase
        relay_out_d = relay_logic_d ^ cfg_q.contact_nc;
        overcur_d = overcur;
    end

    // Braking transistor hysteresis and setting check
    always_comb begin
        bt_d = bt_q;
        if (meas_i.dc_bus > cfg_q.bt_on) begin
            bt_d = 1'b1;
        end else if (meas_i.dc_bus <= cfg_q.bt_off) begin
            bt_d = 1'b0;
        end
        // With the thresholds inverted the chopper could chatter; flag it
        param_err_d = cfg_q.bt_off > cfg_q.bt_on;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            relay_logic_q <= 1'b0;
            relay_out_q <= 1'b0;
            brake_hold_q <= 1'b0;
            bt_q <= 1'b0;
            param_err_q <= 1'b0;
            overcur_q <= 1'b0;
        end else if (ce_i) begin
            relay_logic_q <= relay_logic_d;
            relay_out_q <= relay_out_d;
            brake_hold_q <= brake_hold_d;
            bt_q <= bt_d;
            param_err_q <= param_err_d;
            overcur_q <= overcur_d;
        end
    end

    // Status word built from registered state only
    always_comb begin
        status = '0;
        status[rlbc_pkg::ST_RELAY_LOGIC_BIT] = relay_logic_q;
        status[rlbc_pkg::ST_RELAY_OUT_BIT] = relay_out_q;
        status[rlbc_pkg::ST_BT_BIT] = bt_q;
        status[rlbc_pkg::ST_PARAM_ERR_BIT] = param_err_q;
        status[rlbc_pkg::ST_BRAKE_HOLD_BIT] = brake_hold_q;
        status[rlbc_pkg::ST_OVERCUR_BIT] = overcur_q;
    end

    // Read data valid only in the cycle after the strobe
    always_comb begin
        rd_data_d = '0;
        if (rd_en_i) begin
            unique case (addr_i)
                rlbc_pkg::ADDR_CTRL: begin
                    rd_data_d[rlbc_pkg::CTRL_SEL_LSB +: rlbc_pkg::SEL_W] = cfg_q.func_sel;
                    rd_data_d[rlbc_pkg::CTRL_CONTACT_BIT] = cfg_q.contact_nc;
                end
                rlbc_pkg::ADDR_FREQ_LEVEL: begin
                    rd_data_d = cfg_q.freq_level;
                end
                rlbc_pkg::ADDR_FREQ_WIDTH: begin
                    rd_data_d = cfg_q.freq_width;
                end
                rlbc_pkg::ADDR_CUR_LEVEL: begin
                    rd_data_d = cfg_q.cur_level;
                end
                rlbc_pkg::ADDR_CUR_PERIOD: begin
                    rd_data_d = cfg_q.cur_period;
                end
                rlbc_pkg::ADDR_BRK_RELEASE: begin
                    rd_data_d = cfg_q.brk_release;
                end
                rlbc_pkg::ADDR_BRK_ENGAGE: begin
                    rd_data_d = cfg_q.brk_engage;
                end
                rlbc_pkg::ADDR_BT_ON: begin
                    rd_data_d = cfg_q.bt_on;
                end
                rlbc_pkg::ADDR_BT_OFF: begin
                    rd_data_d = cfg_q.bt_off;
                end
                rlbc_pkg::ADDR_STATUS: begin
                    rd_data_d = status;
                end
                default: begin
                    rd_data_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_data_q <= '0;
        end else if (ce_i) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o = rd_data_q;
    assign relay_output_o = relay_out_q;
    assign brake_transistor_o = bt_q;
    assign parameter_setting_error_o = param_err_q;

endmodule

// ### design/rlbc_pkg.sv
// Constants, types and register map of the relay output and brake chopper logic
package rlbc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SEL_W = 4;

    // Register indices
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_LEVEL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_WIDTH = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CUR_LEVEL = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_CUR_PERIOD = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_BRK_RELEASE = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_BRK_ENGAGE = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_BT_ON = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_BT_OFF = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h9;

    // Control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_CONTACT_BIT = 4;

    // Status register fields
    localparam int ST_RELAY_LOGIC_BIT = 0;
    localparam int ST_RELAY_OUT_BIT = 1;
    localparam int ST_BT_BIT = 2;
    localparam int ST_PARAM_ERR_BIT = 3;
    localparam int ST_BRAKE_HOLD_BIT = 4;
    localparam int ST_OVERCUR_BIT = 5;

    // Units: frequency 0.01 Hz, current 0.1 A, time 0.1 s, voltage 0.1 V
    localparam logic [DATA_W-1:0] ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] FREQ_TOL = 16'h0001;
    localparam logic [DATA_W-1:0] FREQ_LEVEL_MAX = 16'hfde8;
    localparam logic [DATA_W-1:0] FREQ_WIDTH_MAX = 16'h7530;
    localparam logic [DATA_W-1:0] CUR_LEVEL_MIN = 16'h0001;
    localparam logic [DATA_W-1:0] CUR_LEVEL_MAX = 16'h0096;
    localparam logic [DATA_W-1:0] CUR_PERIOD_MIN = 16'h0001;
    localparam logic [DATA_W-1:0] CUR_PERIOD_MAX = 16'h0064;
    localparam logic [DATA_W-1:0] BRK_LEVEL_MAX = 16'h07d0;
    localparam logic [DATA_W-1:0] BT_MIN = 16'h0960;
    localparam logic [DATA_W-1:0] BT_MAX = 16'h0fa0;

    // Reset values
    localparam logic [DATA_W-1:0] RST_FREQ_LEVEL = 16'h0000;
    localparam logic [DATA_W-1:0] RST_FREQ_WIDTH = 16'h0000;
    localparam logic [DATA_W-1:0] RST_CUR_LEVEL = 16'h0001;
    localparam logic [DATA_W-1:0] RST_CUR_PERIOD = 16'h0001;
    localparam logic [DATA_W-1:0] RST_BRK_LEVEL = 16'h0000;
    localparam logic [DATA_W-1:0] RST_BT_ON = 16'h0ed8;
    localparam logic [DATA_W-1:0] RST_BT_OFF = 16'h0e10;

    typedef enum logic [SEL_W-1:0] {
        RLBC_FN_RUN = 4'b0000,
        RLBC_FN_FAULT = 4'b0001,
        RLBC_FN_FREQ_REACHED = 4'b0010,
        RLBC_FN_FREQ_WINDOW = 4'b0011,
        RLBC_FN_ABOVE_LEVEL = 4'b0100,
        RLBC_FN_BELOW_LEVEL = 4'b0101,
        RLBC_FN_OVERCURRENT = 4'b1101,
        RLBC_FN_EXT_BRAKE = 4'b1110
    } rlbc_func_e;

    typedef struct packed {
        logic run;
        logic fault;
        logic accel;
        logic decel;
        logic [DATA_W-1:0] set_freq;
        logic [DATA_W-1:0] out_freq;
        logic [DATA_W-1:0] out_cur;
        logic [DATA_W-1:0] dc_bus;
    } rlbc_meas_s;

    typedef struct packed {
        logic [SEL_W-1:0] func_sel;
        logic contact_nc;
        logic [DATA_W-1:0] freq_level;
        logic [DATA_W-1:0] freq_width;
        logic [DATA_W-1:0] cur_level;
        logic [DATA_W-1:0] cur_period;
        logic [DATA_W-1:0] brk_release;
        logic [DATA_W-1:0] brk_engage;
        logic [DATA_W-1:0] bt_on;
        logic [DATA_W-1:0] bt_off;
    } rlbc_cfg_s;

endpackage

// ### design/rlbc_window.sv
// Saturating window comparator: value inside [base - below, base + above]
`timescale 1ns/1ps
module rlbc_window #(
    parameter int W = 16
) (
    input wire logic [W-1:0] value_i,
    input wire logic [W-1:0] base_i,
    input wire logic [W-1:0] below_i,
    input wire logic [W-1:0] above_i,
    output logic inside_o
);
    logic [W-1:0] lo;
    logic [W:0] hi;

    always_comb begin
        // Lower edge clips at zero rather than wrapping to a huge value
        if (base_i >= below_i) begin
            lo = base_i - below_i;
        end else begin
            lo = '0;
        end
        // One extra bit keeps the upper edge from wrapping
        hi = {1'b0, base_i} + {1'b0, above_i};
        inside_o = (value_i >= lo) && ({1'b0, value_i} <= hi);
    end
endmodule

// ### tb/rlbc_relay_load.sv
// Model of the relay load, brake coil and braking resistor at the block's far side
`timescale 1ns/1ps
module rlbc_relay_load (
    input wire logic relay_output_i,
    input wire logic brake_transistor_i,
    output logic contact_closed_o,
    output logic resistor_loaded_o
);
    // The contact follows the coil with no bounce modelled, so timing checks stay exact
    assign contact_closed_o = relay_output_i;
    assign resistor_loaded_o = brake_transistor_i;
endmodule

// ### tb/rlbc_core_monitor.sv
// Assertion checker for the relay selector and brake chopper outputs
`timescale 1ns/1ps
module rlbc_core_monitor #(
    parameter logic [rlbc_pkg::DATA_W-1:0] BT_LEVEL_MIN = rlbc_pkg::BT_MIN,
    parameter logic [rlbc_pkg::DATA_W-1:0] BT_LEVEL_MAX = rlbc_pkg::BT_MAX
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [rlbc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [rlbc_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [rlbc_pkg::DATA_W-1:0] rd_data_o,
    input wire rlbc_pkg::rlbc_meas_s meas_i,
    input wire logic relay_output_o,
    input wire logic brake_transistor_o,
    input wire logic parameter_setting_error_o
);
    logic [3:0] sel_q;
    logic nc_q;
    logic [15:0] lvl_q, cur_q, on_q, off_q;
    logic inv_w;
    logic above_w;
    function automatic logic [15:0] clip(input logic [15:0] v, lo, hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    assign inv_w = off_q > on_q;
    assign above_w = meas_i.out_freq > lvl_q;
    // Shadow of the settings, so each check uses what the design holds
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sel_q <= 4'h0;
            nc_q <= 1'b0;
            lvl_q <= rlbc_pkg::RST_FREQ_LEVEL;
            cur_q <= rlbc_pkg::RST_CUR_LEVEL;
            on_q <= rlbc_pkg::RST_BT_ON;
            off_q <= rlbc_pkg::RST_BT_OFF;
        end else if (ce_i && wr_en_i) begin
            case (addr_i)
                rlbc_pkg::ADDR_CTRL: begin
                    sel_q <= wr_data_i[3:0];
                    nc_q <= wr_data_i[4];
                end
                rlbc_pkg::ADDR_FREQ_LEVEL: lvl_q <= clip(wr_data_i, 16'h0000, 16'hfde8);
                rlbc_pkg::ADDR_CUR_LEVEL: cur_q <= clip(wr_data_i, 16'h0001, 16'h0096);
                rlbc_pkg::ADDR_BT_ON: on_q <= clip(wr_data_i, BT_LEVEL_MIN, BT_LEVEL_MAX);
                rlbc_pkg::ADDR_BT_OFF: off_q <= clip(wr_data_i, BT_LEVEL_MIN, BT_LEVEL_MAX);
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    property p_run_on;
        ce_i && sel_q == 4'h0 && meas_i.run |=> relay_output_o != $past(nc_q);
    endproperty
    a_run_on: assert property (p_run_on) else $error("relay off while running");
    property p_fault_on;
        ce_i && sel_q == 4'h1 && meas_i.fault |=> relay_output_o != $past(nc_q);
    endproperty
    a_fault_on: assert property (p_fault_on) else $error("relay off on fault");
    property p_above;
        ce_i && sel_q == 4'h4 |=> (relay_output_o != $past(nc_q)) == $past(above_w);
    endproperty
    a_above: assert property (p_above) else $error("above level relay wrong");
    property p_cur_on;
        ce_i && sel_q == 4'hd && meas_i.out_cur > cur_q |=> relay_output_o != $past(nc_q);
    endproperty
    a_cur_on: assert property (p_cur_on) else $error("overcurrent relay late");
    property p_cur_off;
        ce_i && sel_q == 4'hd && meas_i.out_cur <= cur_q |=> relay_output_o == $past(nc_q);
    endproperty
    a_cur_off: assert property (p_cur_off) else $error("overcurrent relay stuck");
    property p_bt_on;
        ce_i && meas_i.dc_bus > on_q |=> brake_transistor_o;
    endproperty
    a_bt_on: assert property (p_bt_on) else $error("transistor not on");
    property p_bt_rise;
        $rose(brake_transistor_o) |-> $past(meas_i.dc_bus) > $past(on_q);
    endproperty
    a_bt_rise: assert property (p_bt_rise) else $error("transistor on without cause");
    property p_bt_off;
        ce_i && meas_i.dc_bus <= off_q && meas_i.dc_bus <= on_q |=> !brake_transistor_o;
    endproperty
    a_bt_off: assert property (p_bt_off) else $error("transistor not off");
    property p_bt_fall;
        $fell(brake_transistor_o) && !$past(sys_rst_i) |-> $past(meas_i.dc_bus) <= $past(off_q);
    endproperty
    a_bt_fall: assert property (p_bt_fall) else $error("transistor off too early");
    property p_perr;
        ce_i |=> parameter_setting_error_o == $past(inv_w);
    endproperty
    a_perr: assert property (p_perr) else $error("setting error flag wrong");
    c_brake_rel: cover property (sel_q == 4'he && $rose(relay_output_o));
    c_bt_rise: cover property ($rose(brake_transistor_o));
    c_perr: cover property ($rose(parameter_setting_error_o));
endmodule

bind rlbc_core rlbc_core_monitor #(
    .BT_LEVEL_MIN(BT_LEVEL_MIN), .BT_LEVEL_MAX(BT_LEVEL_MAX)
) u_mon (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .meas_i(meas_i), .relay_output_o(relay_output_o), .brake_transistor_o(brake_transistor_o),
    .parameter_setting_error_o(parameter_setting_error_o)
);

// ### tb/rlbc_core_tb_top.sv
// Self-checking testbench for the relay selector and brake chopper block
`timescale 1ns/1ps
module rlbc_core_tb_top;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [15:0] rd_data_o;
    rlbc_pkg::rlbc_meas_s meas_i = '0;
    logic relay_output_o, brake_transistor_o, parameter_setting_error_o;
    logic contact_closed, resistor_loaded;
    logic nc_v = 1'b0;
    int n_errors = 0;
    int check_count = 0;
`define CHK(a, e) chk(16'(a), 16'(e))
    always #2.5 clock_i = ~clock_i;
    rlbc_core dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .meas_i(meas_i), .relay_output_o(relay_output_o), .brake_transistor_o(brake_transistor_o),
        .parameter_setting_error_o(parameter_setting_error_o));
    rlbc_relay_load load (.relay_output_i(relay_output_o), .brake_transistor_i(brake_transistor_o),
        .contact_closed_o(contact_closed), .resistor_loaded_o(resistor_loaded));
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        check_count++;
        if (a !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clock_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clock_i);
        rd_en_i <= 1'b0;
        #1;
        `CHK(rd_data_o, e);
    endtask
    task automatic set_sel(input logic [3:0] s, input logic nc);
        wr(rlbc_pkg::ADDR_CTRL, {11'h000, nc, s});
        nc_v = nc;
    endtask
    // Flags are run, fault, accel, decel; e is the relay state before contact mapping
    task automatic rel(input logic [15:0] sf, of, cur, input logic [3:0] fl, input logic e);
        @(posedge clock_i);
        meas_i <= {fl, sf, of, cur, meas_i.dc_bus};
        @(posedge clock_i);
        #1;
        `CHK(relay_output_o, e ^ nc_v);
        `CHK(contact_closed, e ^ nc_v);
    endtask
    task automatic bus(input logic [15:0] dc, input logic e);
        @(posedge clock_i);
        meas_i.dc_bus <= dc;
        @(posedge clock_i);
        #1;
        `CHK(brake_transistor_o, e);
        `CHK(resistor_loaded, e);
    endtask
    task automatic t_regs();
        `CHK({relay_output_o, brake_transistor_o, parameter_setting_error_o}, 3'h0);
        rd(rlbc_pkg::ADDR_BT_ON, rlbc_pkg::RST_BT_ON);
        rd(rlbc_pkg::ADDR_BT_OFF, rlbc_pkg::RST_BT_OFF);
        wr(rlbc_pkg::ADDR_CUR_LEVEL, 16'h0000);
        rd(rlbc_pkg::ADDR_CUR_LEVEL, rlbc_pkg::CUR_LEVEL_MIN);
        wr(rlbc_pkg::ADDR_CUR_LEVEL, 16'h00ff);
        rd(rlbc_pkg::ADDR_CUR_LEVEL, rlbc_pkg::CUR_LEVEL_MAX);
        wr(rlbc_pkg::ADDR_CUR_PERIOD, 16'h00c8);
        rd(rlbc_pkg::ADDR_CUR_PERIOD, rlbc_pkg::CUR_PERIOD_MAX);
        rd(4'ha, 16'h0000);
    endtask
    task automatic t_codes();
        wr(rlbc_pkg::ADDR_FREQ_LEVEL, 16'h0bb8);
        wr(rlbc_pkg::ADDR_FREQ_WIDTH, 16'h01f4);
        wr(rlbc_pkg::ADDR_CUR_LEVEL, 16'h0032);
        set_sel(4'h0, 1'b0);
        rel(16'h0, 16'h0, 16'h0, 4'h8, 1'b1);
        rel(16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
        set_sel(4'h1, 1'b0);
        rel(16'h0, 16'h0, 16'h0, 4'h4, 1'b1);
        rel(16'h0, 16'h0, 16'h0, 4'h8, 1'b0);
        set_sel(4'h2, 1'b0);
        rel(16'h0bb8, 16'h09c4, 16'h0, 4'h8, 1'b1);
        rel(16'h0bb8, 16'h09c3, 16'h0, 4'h8, 1'b1);
        rel(16'h0bb8, 16'h09c2, 16'h0, 4'h8, 1'b0);
        rel(16'h0bb8, 16'h0bb9, 16'h0, 4'h8, 1'b1);
        rel(16'h0bb8, 16'h0bba, 16'h0, 4'h8, 1'b0);
        rel(16'h0bb8, 16'h0af0, 16'h0, 4'h0, 1'b0);
        set_sel(4'h3, 1'b0);
        rel(16'h09c4, 16'h0dac, 16'h0, 4'h0, 1'b1);
        rel(16'h0e10, 16'h0bb8, 16'h0, 4'h8, 1'b0);
        rel(16'h09c3, 16'h0bb8, 16'h0, 4'h8, 1'b0);
        set_sel(4'h4, 1'b0);
        rel(16'h0, 16'h0bb9, 16'h0, 4'h0, 1'b1);
        rel(16'h0, 16'h0bb8, 16'h0, 4'h0, 1'b0);
        set_sel(4'h5, 1'b0);
        rel(16'h0, 16'h0bb7, 16'h0, 4'h0, 1'b1);
        rel(16'h0, 16'h0bb8, 16'h0, 4'h0, 1'b0);
        set_sel(4'hd, 1'b0);
        rel(16'h0, 16'h0, 16'h0033, 4'h0, 1'b1);
        rel(16'h0, 16'h0, 16'h0032, 4'h0, 1'b0);
        set_sel(4'h7, 1'b0);
        rel(16'h0, 16'h0, 16'h0, 4'hf, 1'b0);
        set_sel(4'h0, 1'b1);
        rel(16'h0, 16'h0, 16'h0, 4'h8, 1'b1);
        rel(16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
        set_sel(4'hf, 1'b1);
        rel(16'h0, 16'h0, 16'h0, 4'hf, 1'b0);
    endtask
    task automatic t_ext_brake();
        wr(rlbc_pkg::ADDR_BRK_RELEASE, 16'h01f4);
        wr(rlbc_pkg::ADDR_BRK_ENGAGE, 16'h012c);
        set_sel(4'he, 1'b0);
        rel(16'h0, 16'h01f3, 16'h0, 4'h2, 1'b0);
        rel(16'h0, 16'h01f4, 16'h0, 4'h2, 1'b1);
        rel(16'h0, 16'h00c8, 16'h0, 4'h0, 1'b1);
        rel(16'h0, 16'h012d, 16'h0, 4'h1, 1'b1);
        rel(16'h0, 16'h012c, 16'h0, 4'h1, 1'b0);
        // Engage above release: the relay must drop at once on deceleration
        wr(rlbc_pkg::ADDR_BRK_RELEASE, 16'h012c);
        wr(rlbc_pkg::ADDR_BRK_ENGAGE, 16'h01f4);
        rel(16'h0, 16'h012c, 16'h0, 4'h2, 1'b1);
        rel(16'h0, 16'h01f4, 16'h0, 4'h1, 1'b0);
    endtask
    task automatic t_chopper();
        bus(16'h0ed8, 1'b0);
        bus(16'h0ed9, 1'b1);
        bus(16'h0e74, 1'b1);
        bus(16'h0e10, 1'b0);
        bus(16'h0e74, 1'b0);
        wr(rlbc_pkg::ADDR_BT_OFF, 16'h0f3c);
        bus(16'h0f0a, 1'b1);
        `CHK(parameter_setting_error_o, 1'b1);
        rd(rlbc_pkg::ADDR_STATUS, 16'h000c);
        wr(rlbc_pkg::ADDR_BT_OFF, 16'h0e10);
        bus(16'h0e10, 1'b0);
        `CHK(parameter_setting_error_o, 1'b0);
        // Enable low must hold the transistor off although the bus is high
        @(posedge clock_i);
        ce_i <= 1'b0;
        bus(16'h0fa0, 1'b0);
        @(posedge clock_i);
        ce_i <= 1'b1;
        bus(16'h0fa0, 1'b1);
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole run is about 150 cycles, so this limit only trips on a hang
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        t_regs();
        t_codes();
        t_ext_brake();
        t_chopper();
        report_and_stop();
    end
endmodule
